/* File: pmd_regs.sv */
// apb register bank for phy management and cable diagnostics
module pmd_regs
#(
   // arbitrary neutral identifier value
   parameter logic [15:0] PHY2_IDENT_HIGH = 16'h5a5a
)
(
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 sys_rst,
   // apb slave
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   input  wire logic [3:0]           pstrb,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   // cable diagnostic engines, index 0 is phy1, index 1 is phy2
   output logic      [1:0]           diag_start,
   input  wire logic [1:0]           diag_done,
   input  wire logic [1:0][1:0]      diag_result_in,
   input  wire logic [1:0]           diag_near_short_in,
   input  wire logic [1:0][8:0]      diag_count_in,
   // phy1 special control and status
   input  wire logic                 phy1_polarity_reversed,
   input  wire logic                 phy1_crossover_state,
   output logic                      phy1_force_link,
   output logic                      phy1_power_save_disable,
   output logic                      phy1_near_loopback,
   // phy2 auto-negotiation
   output logic                      phy2_adv_pause,
   output logic      [3:0]           phy2_adv_modes,
   input  wire logic                 phy2_partner_pause,
   input  wire logic [3:0]           phy2_partner_modes
);

   // ==========================================================
   // state
   typedef struct packed {
      logic [31:0]      rdata;
      logic             slverr;
      logic [1:0]       busy;
      logic [1:0]       start;
      logic [1:0][1:0]  result;
      logic [1:0]       near_short;
      logic [1:0][8:0]  count;
      logic             adv_pause;
      logic [3:0]       adv_modes;
      logic             force_link;
      logic             pwrsave_dis;
      logic             loopback;
      logic             lp_pause;
      logic [3:0]       lp_modes;
      logic             polarity;
      logic             xover;
   } pmd_state_s;

   pmd_state_s st_reg;
   pmd_state_s st_next;

   logic       setup;
   logic       wr;
   logic       aligned;
   logic [5:0] idx;
   logic [1:0] diag_wr;
   logic [15:0] diag_word [2];
   logic [15:0] adv_word;
   logic [15:0] lp_word;
   logic [15:0] spc_word;

   assign setup   = psel & ~penable;
   assign wr      = psel & penable & pwrite;
   assign aligned = (paddr[1:0] == 2'h0);
   assign idx     = paddr[7:2];
   // zero wait states: read data is fetched in the setup cycle
   assign pready  = 1'b1;

   // ==========================================================
   // read words; every register except the fixed phy2 identifier is assembled from stored state
   always_comb
   begin
      for (int i = 0; i < 2; i++)
      begin
         diag_word[i] = 16'h0000;
         diag_word[i][pmd_pkg::DIAG_START_BIT] = st_reg.busy[i];
         diag_word[i][pmd_pkg::DIAG_RESULT_LO +: 2] = st_reg.result[i];
         diag_word[i][pmd_pkg::DIAG_SHORT_BIT] = st_reg.near_short[i];
         diag_word[i][pmd_pkg::DIAG_COUNT_W-1:0] = st_reg.count[i];
      end
      // bits 15, 14, 13 stay zero
      adv_word = {11'h000, pmd_pkg::ABIL_LOW_FIXED};
      adv_word[pmd_pkg::ABIL_PAUSE_BIT] = st_reg.adv_pause;
      adv_word[pmd_pkg::ABIL_MODES_LO +: 4] = st_reg.adv_modes;
      lp_word = {11'h000, pmd_pkg::ABIL_LOW_FIXED};
      lp_word[pmd_pkg::ABIL_PAUSE_BIT] = st_reg.lp_pause;
      lp_word[pmd_pkg::ABIL_MODES_LO +: 4] = st_reg.lp_modes;
      spc_word = 16'h0000;
      spc_word[pmd_pkg::SPC_POLARITY_BIT] = st_reg.polarity;
      spc_word[pmd_pkg::SPC_XOVER_BIT] = st_reg.xover;
      spc_word[pmd_pkg::SPC_FORCE_BIT] = st_reg.force_link;
      spc_word[pmd_pkg::SPC_PWRSAVE_BIT] = st_reg.pwrsave_dis;
      spc_word[pmd_pkg::SPC_LOOPBACK_BIT] = st_reg.loopback;
   end

   // ==========================================================
   // next state
   always_comb
   begin
      st_next = st_reg;
      st_next.start = 2'b00;
      // status follows the phys every cycle
      st_next.polarity = phy1_polarity_reversed;
      st_next.xover    = phy1_crossover_state;
      st_next.lp_pause = phy2_partner_pause;
      st_next.lp_modes = phy2_partner_modes;

      // read path
      if (setup)
      begin
         st_next.slverr = 1'b0;
         if (!aligned)
         begin
            st_next.rdata  = 32'h0000_0000;
            st_next.slverr = 1'b1;
         end
         else if (idx == pmd_pkg::IDX_PHY1_DIAG)
            st_next.rdata = {16'h0000, diag_word[0]};
         else if (idx == pmd_pkg::IDX_PHY1_SPECIAL)
            st_next.rdata = {16'h0000, spc_word};
         else if (idx == pmd_pkg::IDX_PHY2_DIAG)
            st_next.rdata = {16'h0000, diag_word[1]};
         else if (idx == pmd_pkg::IDX_PHY2_IDENT)
            st_next.rdata = {16'h0000, PHY2_IDENT_HIGH};
         else if (idx == pmd_pkg::IDX_PHY2_ADV)
            st_next.rdata = {16'h0000, adv_word};
         else if (idx == pmd_pkg::IDX_PHY2_PARTNER)
            st_next.rdata = {16'h0000, lp_word};
         else
         begin
            st_next.rdata  = 32'h0000_0000;
            st_next.slverr = 1'b1;
         end
      end

      // diagnostic engines: results are captured only on a done while busy
      for (int i = 0; i < 2; i++)
      begin
         if (st_reg.busy[i] && diag_done[i])
         begin
            st_next.busy[i]       = 1'b0;
            st_next.result[i]     = diag_result_in[i];
            st_next.near_short[i] = diag_near_short_in[i];
            st_next.count[i]      = diag_count_in[i];
         end
         // a running test cannot be aborted or restarted; a start written in the done cycle wins
         if (diag_wr[i] && pwdata[pmd_pkg::DIAG_START_BIT] && (!st_reg.busy[i] || diag_done[i]))
         begin
            st_next.busy[i]  = 1'b1;
            st_next.start[i] = 1'b1;
         end
      end

      // writable control bits; all other bits are ignored on write
      if (wr && aligned && idx == pmd_pkg::IDX_PHY2_ADV)
      begin
         if (pstrb[1])
            st_next.adv_pause = pwdata[pmd_pkg::ABIL_PAUSE_BIT];
         if (pstrb[1])
            st_next.adv_modes[3] = pwdata[pmd_pkg::ABIL_MODES_LO+3];
         if (pstrb[0])
            st_next.adv_modes[2:0] = pwdata[pmd_pkg::ABIL_MODES_LO +: 3];
      end
      if (wr && aligned && idx == pmd_pkg::IDX_PHY1_SPECIAL && pstrb[0])
      begin
         st_next.force_link  = pwdata[pmd_pkg::SPC_FORCE_BIT];
         st_next.pwrsave_dis = pwdata[pmd_pkg::SPC_PWRSAVE_BIT];
         st_next.loopback    = pwdata[pmd_pkg::SPC_LOOPBACK_BIT];
      end
   end

   // start bit sits in byte lane 1
   assign diag_wr[0] = wr && aligned && pstrb[1] && (idx == pmd_pkg::IDX_PHY1_DIAG);
   assign diag_wr[1] = wr && aligned && pstrb[1] && (idx == pmd_pkg::IDX_PHY2_DIAG);

   // ==========================================================
   // registers
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         st_reg             <= '0;
         // short flag has no defined reset value; zero is used
         st_reg.adv_pause   <= pmd_pkg::ADV_PAUSE_RST;
         st_reg.adv_modes   <= pmd_pkg::ADV_MODES_RST;
         st_reg.force_link  <= pmd_pkg::FORCE_LINK_RST;
         st_reg.pwrsave_dis <= pmd_pkg::PWRSAVE_DIS_RST;
         st_reg.loopback    <= pmd_pkg::LOOPBACK_RST;
         st_reg.result      <= {pmd_pkg::DIAG_NORMAL, pmd_pkg::DIAG_NORMAL};
      end
      else
         st_reg <= st_next;
   end

   // ==========================================================
   // outputs
   assign prdata                  = st_reg.rdata;
   assign pslverr                 = st_reg.slverr & psel & penable;
   assign diag_start              = st_reg.start;
   assign phy1_force_link         = st_reg.force_link;
   assign phy1_power_save_disable = st_reg.pwrsave_dis;
   assign phy1_near_loopback      = st_reg.loopback;
   assign phy2_adv_pause          = st_reg.adv_pause;
   assign phy2_adv_modes          = st_reg.adv_modes;

   // ==========================================================
   // checks
   a_start_sets_busy: assert property (@(posedge clk) disable iff (sys_rst)
      (diag_wr[0] && pwdata[15] && !st_reg.busy[0]) |=> (diag_start[0] && st_reg.busy[0] ##1 !diag_start[0]))
      else $error("diagnostic start did not set busy with a one-cycle start pulse");

   a_done_clears_busy: assert property (@(posedge clk) disable iff (sys_rst)
      (st_reg.busy[1] && diag_done[1] && !diag_wr[1]) |=> !st_reg.busy[1])
      else $error("diagnostic busy did not clear on done");

   a_result_capture: assert property (@(posedge clk) disable iff (sys_rst)
      (st_reg.busy[0] && diag_done[0]) |=>
         (st_reg.result[0] == $past(diag_result_in[0]) && st_reg.count[0] == $past(diag_count_in[0])))
      else $error("diagnostic result not captured on done");

   a_result_stable: assert property (@(posedge clk) disable iff (sys_rst)
      !(st_reg.busy[1] && diag_done[1]) |=> $stable(st_reg.count[1]) && $stable(st_reg.near_short[1]))
      else $error("diagnostic result changed without done");

   a_ident_fixed: assert property (@(posedge clk) disable iff (sys_rst)
      (setup && aligned && idx == pmd_pkg::IDX_PHY2_IDENT) |=> (prdata == {16'h0000, PHY2_IDENT_HIGH}))
      else $error("identifier read returned a wrong value");

   a_adv_zero_bits: assert property (@(posedge clk) disable iff (sys_rst)
      (setup && aligned && idx == pmd_pkg::IDX_PHY2_ADV) |=>
         (prdata[15] == 1'b0 && prdata[13] == 1'b0 && prdata[4:0] == 5'h01 && prdata[10] == phy2_adv_pause))
      else $error("advertisement read has wrong fixed bits");

   a_partner_read: assert property (@(posedge clk) disable iff (sys_rst)
      (setup && aligned && idx == pmd_pkg::IDX_PHY2_PARTNER) |=>
         (prdata[14] == 1'b0 && prdata[8:5] == $past(st_reg.lp_modes)))
      else $error("partner ability read is wrong");

   a_unmapped_error: assert property (@(posedge clk) disable iff (sys_rst)
      (setup && aligned && idx == 6'h01) |=> (pslverr && prdata == 32'h0000_0000))
      else $error("unmapped access not answered with an error");

   a_reset_controls: assert property (@(posedge clk)
      sys_rst |=> (phy1_power_save_disable && !phy1_force_link && phy2_adv_modes == 4'hf && phy2_adv_pause))
      else $error("control bits wrong after reset");

   a_loopback_write: assert property (@(posedge clk) disable iff (sys_rst)
      (wr && aligned && idx == pmd_pkg::IDX_PHY1_SPECIAL && pstrb[0]) |=> (phy1_near_loopback == $past(pwdata[1])))
      else $error("loopback control not written");

   a_pause_write: assert property (@(posedge clk) disable iff (sys_rst)
      (wr && aligned && idx == pmd_pkg::IDX_PHY2_ADV && pstrb[1])
      |=>
      (phy2_adv_pause == $past(pwdata[10])))
      else $error("pause advertisement not written");

   a_modes_low_write: assert property (@(posedge clk) disable iff (sys_rst)
      (wr && aligned && idx == pmd_pkg::IDX_PHY2_ADV && pstrb[0])
      |=>
      (phy2_adv_modes[2:0] == $past(pwdata[7:5])))
      else $error("low duplex modes not written");

   a_modes_high_write: assert property (@(posedge clk) disable iff (sys_rst)
      (wr && aligned && idx == pmd_pkg::IDX_PHY2_ADV && pstrb[1])
      |=>
      (phy2_adv_modes[3] == $past(pwdata[8])))
      else $error("high duplex mode not written");

   a_adv_hold: assert property (@(posedge clk) disable iff (sys_rst)
      !(wr && aligned && idx == pmd_pkg::IDX_PHY2_ADV)
      |=>
      ($stable(phy2_adv_pause) && $stable(phy2_adv_modes)))
      else $error("advertisement changed without a write");

   a_force_write: assert property (@(posedge clk) disable iff (sys_rst)
      (wr && aligned && idx == pmd_pkg::IDX_PHY1_SPECIAL && pstrb[0])
      |=>
      (phy1_force_link == $past(pwdata[3])))
      else $error("force link control not written");

   a_pwrsave_write: assert property (@(posedge clk) disable iff (sys_rst)
      (wr && aligned && idx == pmd_pkg::IDX_PHY1_SPECIAL && pstrb[0])
      |=>
      (phy1_power_save_disable == $past(pwdata[2])))
      else $error("power save control not written");

   a_special_hold: assert property (@(posedge clk) disable iff (sys_rst)
      !(wr && aligned && idx == pmd_pkg::IDX_PHY1_SPECIAL && pstrb[0])
      |=>
      ($stable(phy1_force_link) && $stable(phy1_power_save_disable) && $stable(phy1_near_loopback)))
      else $error("special controls changed without a write");

   a_polarity_read: assert property (@(posedge clk) disable iff (sys_rst)
      (setup && aligned && idx == pmd_pkg::IDX_PHY1_SPECIAL)
      |=>
      (prdata[5] == $past(st_reg.polarity) && prdata[0] == 1'b0))
      else $error("polarity status read is wrong");

   a_xover_read: assert property (@(posedge clk) disable iff (sys_rst)
      (setup && aligned && idx == pmd_pkg::IDX_PHY1_SPECIAL)
      |=>
      (prdata[4] == $past(st_reg.xover) && prdata[15:6] == 10'h000))
      else $error("crossover status read is wrong");

   a_special_ctrl_read: assert property (@(posedge clk) disable iff (sys_rst)
      (setup && aligned && idx == pmd_pkg::IDX_PHY1_SPECIAL)
      |=>
      (prdata[3:1] == {phy1_force_link, phy1_power_save_disable, phy1_near_loopback}))
      else $error("special control read is wrong");

   a_partner_pause: assert property (@(posedge clk) disable iff (sys_rst)
      (setup && aligned && idx == pmd_pkg::IDX_PHY2_PARTNER)
      |=>
      (prdata[10] == $past(st_reg.lp_pause) && prdata[15] == 1'b0 && prdata[4:0] == 5'h01))
      else $error("partner pause read is wrong");

   a_partner_follow: assert property (@(posedge clk) disable iff (sys_rst)
      !sys_rst
      |=>
      (st_reg.lp_modes == $past(phy2_partner_modes) && st_reg.lp_pause == $past(phy2_partner_pause)))
      else $error("partner status not registered");

   a_phy1_follow: assert property (@(posedge clk) disable iff (sys_rst)
      !sys_rst
      |=>
      (st_reg.polarity == $past(phy1_polarity_reversed) && st_reg.xover == $past(phy1_crossover_state)))
      else $error("phy1 status not registered");

   a_adv_read: assert property (@(posedge clk) disable iff (sys_rst)
      (setup && aligned && idx == pmd_pkg::IDX_PHY2_ADV)
      |=>
      (prdata[8:5] == phy2_adv_modes && prdata[14] == 1'b0 && prdata[12:11] == 2'h0 && prdata[9] == 1'b0))
      else $error("advertisement modes read is wrong");

   a_diag_read: assert property (@(posedge clk) disable iff (sys_rst)
      (setup && aligned && idx == pmd_pkg::IDX_PHY1_DIAG)
      |=>
      (prdata[15] == $past(st_reg.busy[0]) && prdata[12] == $past(st_reg.near_short[0]) && prdata[11:9] == 3'h0))
      else $error("phy1 diagnostic read is wrong");

   a_diag2_read: assert property (@(posedge clk) disable iff (sys_rst)
      (setup && aligned && idx == pmd_pkg::IDX_PHY2_DIAG)
      |=>
      (prdata[15] == $past(st_reg.busy[1]) && prdata[14:13] == $past(st_reg.result[1])))
      else $error("phy2 diagnostic read is wrong");

   a_busy_held: assert property (@(posedge clk) disable iff (sys_rst)
      (st_reg.busy[0] && !diag_done[0])
      |=>
      st_reg.busy[0])
      else $error("diagnostic busy cleared without done");

   a_refused_start: assert property (@(posedge clk) disable iff (sys_rst)
      (st_reg.busy[1] && !diag_done[1])
      |=>
      !diag_start[1])
      else $error("start pulse while a test runs");

   a_short_capture: assert property (@(posedge clk) disable iff (sys_rst)
      (st_reg.busy[1] && diag_done[1])
      |=>
      (st_reg.near_short[1] == $past(diag_near_short_in[1]) && st_reg.result[1] == $past(diag_result_in[1])))
      else $error("phy2 short flag not captured");

   a_short_capture0: assert property (@(posedge clk) disable iff (sys_rst)
      (st_reg.busy[0] && diag_done[0])
      |=>
      (st_reg.near_short[0] == $past(diag_near_short_in[0])))
      else $error("phy1 short flag not captured");

   a_err_gated: assert property (@(posedge clk) disable iff (sys_rst)
      !(psel && penable)
      |->
      !pslverr)
      else $error("error response outside an access phase");

endmodule : pmd_regs

/* File: pmd_pkg.sv */
// constants, field layout and reset values for the phy management and cable diagnostic registers
// Contract
// - phy2 identifier high word reads a fixed value; writes never change it.
// - advertisement bit 10 is read/write, resets to 1, offers pause capability.
// - advertisement bits 8 to 5 are read/write, reset to 1, offer duplex modes.
// - advertisement bits 15 and 13 are read-only and always read 0.
// - partner ability bit 10 is read-only, resets to 0, shows partner pause.
// - partner ability bits 8 to 5 are read-only, reset 0, show partner modes.
// - partner ability bit 14 is read-only and always reads 0.
// - writing 1 to diagnostic bit 15 starts a test; it clears when done.
// - while bit 15 reads 1 results are not ready; afterwards they are valid.
// - diagnostic bits 14 to 13: 00 normal, 01 open, 10 short, 11 failed.
// - diagnostic bit 12 is read-only, set for a short nearer than 10 metres.
// - diagnostic bits 8 to 0 hold a read-only fault distance count.
// - phy1 special bit 5 reads 1 while receive polarity is reversed.
// - phy1 special bit 4 reads 1 for straight mdi, 0 for crossed mdix.
// - phy1 special bit 3 forces link pass when set; resets to 0.
// - phy1 special bit 2 set disables power saving; resets to 1.
// - phy1 special bit 1 set loops received signal back to transmit.
// - a second diagnostic register at index 0x04 serves phy2 independently.
package pmd_pkg;

   // ==========================================================
   // register indices, byte address is four times the index
   localparam logic [5:0] IDX_PHY1_DIAG    = 6'h00;
   localparam logic [5:0] IDX_PHY1_SPECIAL = 6'h02;
   localparam logic [5:0] IDX_PHY2_DIAG    = 6'h04;
   localparam logic [5:0] IDX_PHY2_IDENT   = 6'h06;
   localparam logic [5:0] IDX_PHY2_ADV     = 6'h08;
   localparam logic [5:0] IDX_PHY2_PARTNER = 6'h0a;

   // ==========================================================
   // field positions
   localparam int DIAG_START_BIT   = 15;
   localparam int DIAG_RESULT_LO   = 13;
   localparam int DIAG_SHORT_BIT   = 12;
   localparam int DIAG_COUNT_W     = 9;
   localparam int ABIL_PAUSE_BIT   = 10;
   localparam int ABIL_MODES_LO    = 5;
   localparam int SPC_POLARITY_BIT = 5;
   localparam int SPC_XOVER_BIT    = 4;
   localparam int SPC_FORCE_BIT    = 3;
   localparam int SPC_PWRSAVE_BIT  = 2;
   localparam int SPC_LOOPBACK_BIT = 1;

   // ==========================================================
   // reset and fixed values
   localparam logic       ADV_PAUSE_RST   = 1'b1;
   localparam logic [3:0] ADV_MODES_RST   = 4'hf;
   localparam logic       FORCE_LINK_RST  = 1'b0;
   localparam logic       PWRSAVE_DIS_RST = 1'b1;
   localparam logic       LOOPBACK_RST    = 1'b0;
   localparam logic [4:0] ABIL_LOW_FIXED  = 5'h01;

   // ==========================================================
   // diagnostic outcome codes
   localparam logic [1:0] DIAG_NORMAL = 2'h0;
   localparam logic [1:0] DIAG_OPEN   = 2'h1;
   localparam logic [1:0] DIAG_SHORT  = 2'h2;
   localparam logic [1:0] DIAG_FAILED = 2'h3;

endpackage : pmd_pkg

/* File: pmd_regs_tb.sv */
// self-checking testbench for the phy management and cable diagnostic register bank
module testbench;
   timeunit 1ns;
   timeprecision 100ps;

   // ==========================================================
   // signals
   localparam logic [15:0] IDENT = 16'hc3a7;  // arbitrary neutral identifier value
   logic                   clk                     = 1'b0;
   logic                   sys_rst                 = 1'b1;
   logic                   psel                    = 1'b0;
   logic                   penable                 = 1'b0;
   logic                   pwrite                  = 1'b0;
   logic [7:0]             paddr                   = 8'h00;
   logic [31:0]            pwdata                  = 32'h0;
   logic [3:0]             pstrb                   = 4'h0;
   logic [31:0]            prdata;
   logic                   pready;
   logic                   pslverr;
   logic [1:0]             diag_start;
   logic [1:0]             diag_done               = 2'h0;
   logic [1:0][1:0]        diag_result_in          = '0;
   logic [1:0]             diag_near_short_in      = 2'h0;
   logic [1:0][8:0]        diag_count_in           = '0;
   logic                   phy1_polarity_reversed  = 1'b0;
   logic                   phy1_crossover_state    = 1'b0;
   logic                   phy1_force_link;
   logic                   phy1_power_save_disable;
   logic                   phy1_near_loopback;
   logic                   phy2_adv_pause;
   logic [3:0]             phy2_adv_modes;
   logic                   phy2_partner_pause      = 1'b0;
   logic [3:0]             phy2_partner_modes      = 4'h0;
   int                     err_count               = 0;
   int                     n_compared              = 0;
   int                     seed                    = 35535;
   logic [31:0]            rd;
   logic                   err;
   logic [31:0]            r;
   logic [15:0]            w;
   logic [31:0]            exp_d [2];

   pmd_regs #(.PHY2_IDENT_HIGH(IDENT)) dut_u (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .diag_start(diag_start), .diag_done(diag_done), .diag_result_in(diag_result_in),
      .diag_near_short_in(diag_near_short_in), .diag_count_in(diag_count_in),
      .phy1_polarity_reversed(phy1_polarity_reversed), .phy1_crossover_state(phy1_crossover_state),
      .phy1_force_link(phy1_force_link), .phy1_power_save_disable(phy1_power_save_disable),
      .phy1_near_loopback(phy1_near_loopback), .phy2_adv_pause(phy2_adv_pause), .phy2_adv_modes(phy2_adv_modes),
      .phy2_partner_pause(phy2_partner_pause), .phy2_partner_modes(phy2_partner_modes));

   initial
   begin
      forever #2 clk = ~clk;
   end

   // ==========================================================
   // expectations
   function automatic logic [7:0] ad(input logic [5:0] idx);
      return {idx, 2'b00};
   endfunction : ad

   function automatic logic [5:0] dix(input int p);
      return (p == 1) ? pmd_pkg::IDX_PHY2_DIAG : pmd_pkg::IDX_PHY1_DIAG;
   endfunction : dix

   function automatic logic [31:0] exp_adv(input logic [15:0] v);
      return {16'h0, (v & 16'h05e0) | 16'h0001};
   endfunction : exp_adv

   function automatic logic [31:0] exp_part(input logic p, input logic [3:0] m);
      return {16'h0, 5'h0, p, 1'b0, m, 5'h01};
   endfunction : exp_part

   function automatic logic [31:0] exp_spc(input logic pol, input logic x, input logic [15:0] v);
      return {16'h0, 10'h0, pol, x, v[3:1], 1'b0};
   endfunction : exp_spc

   // ==========================================================
   // bus and compare tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [7:0] a, input logic [15:0] d, input logic [3:0] s);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {16'h0, d};
      pstrb <= wr ? s : 4'h0;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      k = 0;
      while (pready !== 1'b1 && k < 32)
      begin
         @(posedge clk);
         k++;
      end
      if (k == 32)
         err_count++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rchk(input logic [5:0] idx, input logic [31:0] e);
      apb(1'b0, ad(idx), 16'h0, 4'h0);
      chk(rd, e);
      chk(32'(err), 32'h0);
   endtask : rchk

   task automatic summarize;
      if (err_count == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : summarize

   // ==========================================================
   // watchdog: the whole sequence needs under a thousand cycles, the limit is 20000
   initial
   begin
      #(4 * 20000);
      err_count++;
      summarize();
   end

   // ==========================================================
   // main sequence
   initial
   begin
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      exp_d[0] = 32'h0;
      exp_d[1] = 32'h0;
      rchk(pmd_pkg::IDX_PHY2_IDENT, {16'h0, IDENT});
      rchk(pmd_pkg::IDX_PHY2_ADV, 32'h0000_05e1);
      rchk(pmd_pkg::IDX_PHY2_PARTNER, 32'h0000_0001);
      rchk(pmd_pkg::IDX_PHY1_SPECIAL, 32'h0000_0004);
      rchk(pmd_pkg::IDX_PHY1_DIAG, 32'h0);
      rchk(pmd_pkg::IDX_PHY2_DIAG, 32'h0);
      // random writes with all-ones and all-zeros first, status inputs moving meanwhile
      for (int i = 0; i < 24; i++)
      begin
         r = $random(seed);
         w = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : r[31:16];
         apb(1'b1, ad(pmd_pkg::IDX_PHY2_ADV), w, 4'hf);
         rchk(pmd_pkg::IDX_PHY2_ADV, exp_adv(w));
         chk(32'({phy2_adv_pause, phy2_adv_modes}), 32'({w[10], w[8:5]}));
         apb(1'b1, ad(pmd_pkg::IDX_PHY2_IDENT), w, 4'hf);
         rchk(pmd_pkg::IDX_PHY2_IDENT, {16'h0, IDENT});
         apb(1'b1, ad(pmd_pkg::IDX_PHY1_SPECIAL), w, 4'hf);
         phy1_polarity_reversed <= r[0];
         phy1_crossover_state <= r[1];
         phy2_partner_pause <= r[2];
         phy2_partner_modes <= r[6:3];
         apb(1'b1, ad(pmd_pkg::IDX_PHY2_PARTNER), w, 4'hf);
         rchk(pmd_pkg::IDX_PHY1_SPECIAL, exp_spc(r[0], r[1], w));
         chk(32'({phy1_force_link, phy1_power_save_disable, phy1_near_loopback}), 32'(w[3:1]));
         rchk(pmd_pkg::IDX_PHY2_PARTNER, exp_part(r[2], r[6:3]));
      end
      // a reset in mid-run must bring every control back to its default
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      rchk(pmd_pkg::IDX_PHY2_ADV, 32'h0000_05e1);
      rchk(pmd_pkg::IDX_PHY1_SPECIAL, exp_spc(r[0], r[1], 16'h0004));
      // byte lane 0 only: the upper lane must keep its bits
      apb(1'b1, ad(pmd_pkg::IDX_PHY2_ADV), 16'hffff, 4'hf);
      apb(1'b1, ad(pmd_pkg::IDX_PHY2_ADV), 16'h0000, 4'h1);
      rchk(pmd_pkg::IDX_PHY2_ADV, exp_adv(16'hff00));
      // unmapped and misaligned places answer with an error and change nothing
      apb(1'b1, 8'h2c, 16'hffff, 4'hf);
      chk(32'(err), 32'h1);
      apb(1'b1, 8'h21, 16'hffff, 4'hf);
      chk(32'(err), 32'h1);
      apb(1'b0, 8'h04, 16'h0, 4'h0);
      chk({rd[30:0], err}, 32'h1);
      rchk(pmd_pkg::IDX_PHY2_ADV, exp_adv(16'hff00));
      // every outcome code on both engines, the other copy must stay put
      for (int p = 0; p < 2; p++)
         for (int c = 0; c < 4; c++)
         begin
            r = $random(seed);
            if (c == 3)
               r[9:1] = 9'h1ff;
            apb(1'b1, ad(dix(p)), 16'h8000, 4'hf);
            @(posedge clk);
            chk(32'(diag_start), 32'(p + 1));
            @(posedge clk);
            chk(32'(diag_start), 32'h0);
            apb(1'b1, ad(dix(p)), 16'h8000, 4'hf);
            @(posedge clk);
            chk(32'(diag_start), 32'h0);
            rchk(dix(p), {16'h0, 1'b1, exp_d[p][14:0]});
            diag_result_in[p] <= c[1:0];
            diag_near_short_in[p] <= r[0];
            diag_count_in[p] <= r[9:1];
            diag_done[p] <= 1'b1;
            @(posedge clk);
            // a late done with other values must be ignored once idle
            diag_result_in[p] <= ~c[1:0];
            diag_near_short_in[p] <= ~r[0];
            diag_count_in[p] <= ~r[9:1];
            @(posedge clk);
            diag_done[p] <= 1'b0;
            exp_d[p] = {16'h0, 1'b0, c[1:0], r[0], 3'h0, r[9:1]};
            rchk(dix(p), exp_d[p]);
            rchk(dix(1 - p), exp_d[1 - p]);
         end
      summarize();
   end

endmodule : testbench
